// ===== pkg/fp_exp_defines.svh
`ifndef FP_EXP_DEFINES_SVH
`define FP_EXP_DEFINES_SVH

// ----------------------------------------------------------------
// exponent format
// ----------------------------------------------------------------
`define EXP_W          8
`define EXP_BIAS       8'h80
`define EXP_ALL_ONES   8'hFF
`define EXP_ZERO       8'h00

// ----------------------------------------------------------------
// field bit positions
// ----------------------------------------------------------------
`define EA_SEL_A_BIT   3
`define EA_ROM_BIT     2
`define EA_F1_BIT      1
`define EA_F0_BIT      0
`define ER_B1_BIT      1
`define ER_B0_BIT      0
`define LATCH_SIGN_BIT 15

// ----------------------------------------------------------------
// constant rom addresses and contents
// ----------------------------------------------------------------
`define ROM_ADDR_ADD_S  5'h08
`define ROM_ADDR_ADD_D  5'h03
`define ROM_ADDR_MUL_S  5'h0E
`define ROM_ADDR_MUL_D  5'h06
`define ROM_ADDR_DIV_S  5'h01
`define ROM_ADDR_DIV_D  5'h1D
`define ROM_ADDR_FLT    5'h11
`define ROM_ADDR_FIX    5'h15
`define ROM_VAL_ADD_S   8'hE9
`define ROM_VAL_ADD_D   8'hD1
`define ROM_VAL_MUL_S   8'h0A
`define ROM_VAL_MUL_D   8'h16
`define ROM_VAL_DIV_S   8'h18
`define ROM_VAL_DIV_D   8'h30
`define ROM_VAL_CONV    8'h8F

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_EXP        8'h00
`define RST_CNT        8'h00

`endif

// ===== pkg/fp_exp_pkg.sv
package fp_exp_pkg;

  // exponent alu function, value equals the two select lines {b,a}
  typedef enum logic [1:0] {
    FN_PASS_INC = 2'h0,
    FN_ADD      = 2'h1,
    FN_SUB      = 2'h2,
    FN_DEC      = 2'h3
  } alu_fn_type;

  // division exponent class
  typedef enum logic [2:0] {
    DC_IN_RANGE  = 3'h0,
    DC_COND_OVF  = 3'h1,
    DC_OVERFLOW  = 3'h3,
    DC_UNDERFLOW = 3'h2,
    DC_COND_UNF  = 3'h6
  } div_class_type;

endpackage

// ===== logic/fp_exponent_control.sv
`timescale 1ns/1ps
`include "fp_exp_defines.svh"
// What this block does
// - divide forms e1 minus e2 plus 128
// - e plus one carry flags all-ones exponent
// - first carry flag groups divide classes
// - exponent bit 7 splits overflow from underflow
// - clamp or increment final divide exponent
// - interrupt on divide overflow or underflow
// - add/sub-128 carry depends on exponent sign
// - inverted sign bit feeds alu a msb
// - otherwise any alu carry sets flag
// - normalize with zero exponent sets flag
// - select a drives s0 s3, b s1 s2
// - add field code picks alu function
// - negative single operand turns add into subtract
// - carry-in high for subtract, not complement
// - add field bits 3,2 give a plus one
// - register field 01 loads exponent register
// - register field 11 loads shift counter
// - register field 10 loads counter if carry low
// - count only in align, multiply, divide steps
// - near-zero when counter bits 1-6 zero
// - add field bit 2 reads rom by opcode
// - rom holds per-instruction constants
// - exponents are 8-bit excess-128 codes
// - normalize counts exponent down each register strobe
module fp_exponent_control #(
  parameter int EXP_W = `EXP_W,
  parameter int CNT_W = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic             register_clock_strobe,
  input  wire logic [3:0]       exp_add_field,
  input  wire logic [1:0]       exp_reg_field,
  input  wire logic             add_sub_128_ctl,
  input  wire logic             normalize_uop,
  input  wire logic             align_uop,
  input  wire logic             main_mult_uop,
  input  wire logic             main_div_uop,
  input  wire logic             load_exp_from_latch,
  input  wire logic             double_prec_sel,
  input  wire logic [15:0]      data_latch,
  input  wire logic [4:0]       instr_reg,
  input  wire logic             shift_clock,
  input  wire logic             div_classify,
  input  wire logic             div_finalize,
  input  wire logic             quotient_ge_one,
  output logic                  exp_carry_flag,
  output logic [EXP_W-1:0]      exp_reg,
  output logic [CNT_W-1:0]      shift_cnt,
  output logic                  exp_is_zero,
  output logic                  count_near_zero,
  output logic                  fp_interrupt,
  output logic [2:0]            div_class
);

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  // declared ahead of the datapath, which reads several of them
  logic                 carry_q, carry_d;          // exponent carry flag
  logic [EXP_W-1:0]     exp_reg_q, exp_reg_d;      // exponent register
  logic [CNT_W-1:0]     shift_cnt_q, shift_cnt_d;  // shift / iteration counter
  logic                 irq_q, irq_d;              // one-cycle interrupt pulse
  logic [2:0]           class_q, class_d;          // divide class, bit 0 first flag
  logic                 zero_q, zero_d;            // exponent equals zero
  logic                 near_q, near_d;            // counter bits 1-6 are zero

  // ----------------------------------------------------------------
  // datapath decode
  // ----------------------------------------------------------------
  logic                 latch_bit_fifteen;  // sign of single operand
  logic [1:0]           fn_code;            // effective function code
  logic                 exp_func_sel_a;     // to s0 and s3
  logic                 exp_func_sel_b;     // to s1 and s2
  logic                 exp_alu_carry_in;   // alu carry input
  logic [EXP_W-1:0]     rom_out;            // constant store output
  logic [EXP_W-1:0]     a_in;               // alu a operand
  logic [EXP_W-1:0]     b_in;               // alu b operand
  logic                 exp_sign_bit;       // top bit of exponent
  logic                 inverted_msb_to_alu;
  logic [EXP_W:0]       alu_sum;            // carry plus result
  logic                 exp_alu_carry_out;
  logic                 exp_reg_load;
  logic                 shift_cnt_load;
  logic                 shift_cnt_count_en;
  logic                 rom_en;

  // loose bits pulled out of the wider inputs
  assign latch_bit_fifteen = data_latch[`LATCH_SIGN_BIT];
  assign exp_sign_bit      = exp_reg_q[EXP_W-1];
  assign rom_en            = exp_add_field[`EA_ROM_BIT];

  // ----------------------------------------------------------------
  // constant store
  // ----------------------------------------------------------------
  // eight per-instruction constants: alignment limits, iteration
  // counts and the conversion exponent; unlisted opcodes read zero
  // so a stray read cannot look like a valid limit
  always_comb begin
    case (instr_reg)
      `ROM_ADDR_ADD_S: rom_out = `ROM_VAL_ADD_S;
      `ROM_ADDR_ADD_D: rom_out = `ROM_VAL_ADD_D;
      `ROM_ADDR_MUL_S: rom_out = `ROM_VAL_MUL_S;
      `ROM_ADDR_MUL_D: rom_out = `ROM_VAL_MUL_D;
      `ROM_ADDR_DIV_S: rom_out = `ROM_VAL_DIV_S;
      `ROM_ADDR_DIV_D: rom_out = `ROM_VAL_DIV_D;
      `ROM_ADDR_FLT:   rom_out = `ROM_VAL_CONV;
      `ROM_ADDR_FIX:   rom_out = `ROM_VAL_CONV;
      default:         rom_out = `EXP_ZERO;
    endcase
  end

  // ----------------------------------------------------------------
  // alu control and operand select
  // ----------------------------------------------------------------
  // function select, carry-in and operand muxes
  // carry-in follows the raw field, not the converted code: a converted
  // add keeps carry low and so yields the ones complement it needs
  always_comb begin
    fn_code = exp_add_field[1:0];
    // negative single operand: add becomes subtract to undo complement
    if (!load_exp_from_latch && !double_prec_sel && latch_bit_fifteen &&
        fn_code == fp_exp_pkg::FN_ADD) begin
      fn_code = fp_exp_pkg::FN_SUB;
    end
    exp_func_sel_a = fn_code[0];
    exp_func_sel_b = fn_code[1];
    // subtract needs carry; complement (a=0 path) stays ones complement
    exp_alu_carry_in = (exp_add_field[1] & ~exp_add_field[0])
                     | (exp_add_field[3] & exp_add_field[2]);
    inverted_msb_to_alu = add_sub_128_ctl ? ~exp_sign_bit : exp_sign_bit;
    // a: exponent register with its top bit maybe flipped, else rom or zero
    if (exp_add_field[`EA_SEL_A_BIT]) begin
      a_in = {inverted_msb_to_alu, exp_reg_q[EXP_W-2:0]};
    end else if (rom_en) begin
      a_in = rom_out;
    end else begin
      a_in = `EXP_ZERO;
    end
    // exponent from latch, else the shift counter
    // double takes the upper latch byte, single the bits under the sign
    if (!load_exp_from_latch) begin
      b_in = double_prec_sel ? data_latch[15:8] : data_latch[14:7];
    end else begin
      b_in = shift_cnt_q[EXP_W-1:0];
    end
    // the alu sees only its two select lines, as the real part would
    case (fp_exp_pkg::alu_fn_type'({exp_func_sel_b, exp_func_sel_a}))
      fp_exp_pkg::FN_ADD: alu_sum = {1'b0, a_in} + {1'b0, b_in}
                                  + {{EXP_W{1'b0}}, exp_alu_carry_in};
      // a minus b: a + ~b + cin, carry means no borrow
      fp_exp_pkg::FN_SUB: alu_sum = {1'b0, a_in} + {1'b0, ~b_in}
                                  + {{EXP_W{1'b0}}, exp_alu_carry_in};
      fp_exp_pkg::FN_DEC: alu_sum = {1'b0, a_in} + {1'b0, `EXP_ALL_ONES}
                                  + {{EXP_W{1'b0}}, exp_alu_carry_in};
      default:            alu_sum = {1'b0, a_in}
                                  + {{EXP_W{1'b0}}, exp_alu_carry_in};
    endcase
  end

  // carry out of bit 7: no borrow on subtract, wrap on add
  assign exp_alu_carry_out = alu_sum[EXP_W];
  // a is e plus/minus 128 and b the other exponent: result is excess-128
  assign exp_reg_load   = ~exp_reg_field[`ER_B1_BIT] & exp_reg_field[`ER_B0_BIT];
  assign shift_cnt_count_en = align_uop | main_mult_uop | main_div_uop;

  // ----------------------------------------------------------------
  // shift counter load and next-state logic
  // ----------------------------------------------------------------

  // counter load: 11 always, 10 only with carry low (negate negative count)
  // the carry test uses the flag as it stands before this strobe, so
  // a subtract in the same step cannot gate its own counter load
  always_comb begin
    shift_cnt_load = 1'b0;
    if (exp_reg_field[`ER_B1_BIT] && exp_reg_field[`ER_B0_BIT]) begin
      shift_cnt_load = 1'b1;
    end else if (exp_reg_field[`ER_B1_BIT] && !carry_q) begin
      shift_cnt_load = 1'b1;
    end
  end

  // next-state for flag, exponent, counter and division class
  // priority: add/sub-128, then normalize, then plain alu carry; the
  // finalize step overrides the exponent last so a clamp always wins
  always_comb begin
    carry_d     = carry_q;
    exp_reg_d   = exp_reg_q;
    shift_cnt_d = shift_cnt_q;
    irq_d       = 1'b0;
    class_d     = class_q;
    if (register_clock_strobe) begin
      // carry flag source
      // each step kind picks its own carry source
      if (add_sub_128_ctl) begin
        // excess code: bit 7 high means the first exponent is not negative,
        // then a carry means out of range; otherwise a borrow does
        carry_d = exp_sign_bit ? exp_alu_carry_out : ~exp_alu_carry_out;
        if (exp_reg_load) begin
          exp_reg_d = alu_sum[EXP_W-1:0];
        end
      end else if (normalize_uop) begin
        carry_d = zero_q ? 1'b1 : carry_q;
        exp_reg_d = exp_reg_q - 8'h01;
      end else begin
        carry_d = exp_alu_carry_out;
        if (exp_reg_load) begin
          exp_reg_d = alu_sum[EXP_W-1:0];
        end
      end
      // classify during the e+1 test: first flag held in class_q[0]
      // the alu is doing e+1 here, so its carry is the all-ones test
      // hard groups raise the interrupt; conditional ones wait for finalize
      if (div_classify) begin
        if (class_q[0]) begin
          if (exp_alu_carry_out) begin
            class_d = fp_exp_pkg::DC_COND_UNF;
          end else if (exp_reg_q[EXP_W-1]) begin
            class_d = fp_exp_pkg::DC_UNDERFLOW;
          end else begin
            class_d = fp_exp_pkg::DC_OVERFLOW;
          end
        end else begin
          class_d = exp_alu_carry_out ? fp_exp_pkg::DC_COND_OVF
                                      : fp_exp_pkg::DC_IN_RANGE;
        end
        // interrupt only for hard overflow/underflow groups
        irq_d = class_q[0] & ~exp_alu_carry_out;
      end else if (add_sub_128_ctl) begin
        // capture the first flag for the later classification step
        class_d = {2'b00, carry_d};
      end
      if (div_finalize) begin
        case (class_q)
          fp_exp_pkg::DC_OVERFLOW:  exp_reg_d = `EXP_ALL_ONES;
          fp_exp_pkg::DC_UNDERFLOW: exp_reg_d = `EXP_ZERO;
          fp_exp_pkg::DC_COND_OVF:  exp_reg_d = `EXP_ALL_ONES;
          // e1-e2 = -129 stays at the floor whatever the quotient
          fp_exp_pkg::DC_COND_UNF:  exp_reg_d = `EXP_ZERO;
          default:                  exp_reg_d = quotient_ge_one ? exp_reg_q + 8'h01
                                                                : exp_reg_q;
        endcase
      end
      if (shift_cnt_load) begin
        // zero-extend when the counter is wider than the alu
        shift_cnt_d = CNT_W'(alu_sum[EXP_W-1:0]);
      end
    end
    // shift clocks count down in the three counting steps only; a load
    // strobe wins, and the count stops at zero instead of wrapping
    if (shift_clock && shift_cnt_count_en &&
        !(register_clock_strobe && shift_cnt_load) && shift_cnt_q != '0) begin
      shift_cnt_d = shift_cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
    end
    zero_d = (exp_reg_d == `EXP_ZERO);
    near_d = (shift_cnt_d[6:1] == 6'h00);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // registers only; reset clears the carry flag, exponent, counter, interrupt and class
  // zero and near flags reset high to match the cleared exp and count
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      carry_q     <= 1'b0;
      exp_reg_q   <= `RST_EXP;
      shift_cnt_q <= `RST_CNT;
      irq_q       <= 1'b0;
      class_q     <= 3'h0;
      zero_q      <= 1'b1;
      near_q      <= 1'b1;
    end else begin
      carry_q     <= carry_d;
      exp_reg_q   <= exp_reg_d;
      shift_cnt_q <= shift_cnt_d;
      irq_q       <= irq_d;
      class_q     <= class_d;
      zero_q      <= zero_d;
      near_q      <= near_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // outputs straight from flops
  // no logic between flop and pin, so outputs settle right after the edge
  assign exp_carry_flag  = carry_q;
  assign exp_reg         = exp_reg_q;
  assign shift_cnt       = shift_cnt_q;
  assign exp_is_zero     = zero_q;
  assign count_near_zero = near_q;
  assign fp_interrupt    = irq_q;
  assign div_class       = class_q;

endmodule // fp_exponent_control

// ===== tb/fp_exp_ctl_sva.sv
`timescale 1ns/1ps
// ----------------------------------------
// exponent control checker
// ----------------------------------------
module fp_exp_ctl_sva #(
  parameter int EXP_W = 8,
  parameter int CNT_W = 8
) (
  input wire logic             sys_clk,
  input wire logic             rstn,
  input wire logic             register_clock_strobe,
  input wire logic [1:0]       exp_reg_field,
  input wire logic             normalize_uop,
  input wire logic             align_uop,
  input wire logic             main_mult_uop,
  input wire logic             main_div_uop,
  input wire logic             shift_clock,
  input wire logic             div_finalize,
  input wire logic             exp_carry_flag,
  input wire logic [EXP_W-1:0] exp_reg,
  input wire logic [CNT_W-1:0] shift_cnt,
  input wire logic             exp_is_zero,
  input wire logic             count_near_zero,
  input wire logic             fp_interrupt,
  input wire logic [2:0]       div_class
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // any of the three counting steps
  wire logic cnt_en = align_uop | main_mult_uop | main_div_uop;
  a_zero_track: assert property (exp_is_zero == (exp_reg == '0))
    else $error("zero flag disagrees with exponent");
  a_near_zero: assert property (count_near_zero == (shift_cnt[6:1] == 6'h00))
    else $error("near zero flag wrong");
  a_exp_hold: assert property (!register_clock_strobe |=> $stable(exp_reg))
    else $error("exponent moved without strobe");
  a_flag_hold: assert property (!register_clock_strobe |=> $stable(exp_carry_flag))
    else $error("carry flag moved without strobe");
  a_irq_pulse: assert property (fp_interrupt |=> !fp_interrupt)
    else $error("interrupt longer than one cycle");
  a_irq_cause: assert property (fp_interrupt |-> div_class inside {3'h2, 3'h3})
    else $error("interrupt outside overflow or underflow");
  a_norm_down: assert property (
    register_clock_strobe && normalize_uop && exp_reg_field == 2'h0
    |=> exp_reg == $past(exp_reg) - 8'h01)
    else $error("normalize did not count down");
  a_norm_flag: assert property (
    register_clock_strobe && normalize_uop && exp_is_zero |=> exp_carry_flag)
    else $error("normalize underflow not flagged");
  a_cnt_idle: assert property (
    shift_clock && !cnt_en && !register_clock_strobe |=> $stable(shift_cnt))
    else $error("counter moved outside counting steps");
  a_cnt_down: assert property (
    shift_clock && cnt_en && !register_clock_strobe && shift_cnt != '0
    |=> shift_cnt == $past(shift_cnt) - 8'h01)
    else $error("counter did not count down");
  a_ovf_clamp: assert property (
    register_clock_strobe && div_finalize && div_class == 3'h3 |=> exp_reg == 8'hFF)
    else $error("overflow not clamped");
  a_unf_clamp: assert property (
    register_clock_strobe && div_finalize && div_class inside {3'h2, 3'h6}
    |=> exp_reg == 8'h00)
    else $error("underflow not cleared");
  c_irq: cover property (fp_interrupt);
  c_near: cover property (count_near_zero && cnt_en && shift_clock);
  c_norm: cover property (register_clock_strobe && normalize_uop && exp_is_zero);
endmodule // fp_exp_ctl_sva

bind fp_exponent_control fp_exp_ctl_sva #(.EXP_W(EXP_W), .CNT_W(CNT_W)) u_sva (
  .sys_clk, .rstn, .register_clock_strobe, .exp_reg_field, .normalize_uop, .align_uop,
  .main_mult_uop, .main_div_uop, .shift_clock, .div_finalize, .exp_carry_flag, .exp_reg,
  .shift_cnt, .exp_is_zero, .count_near_zero, .fp_interrupt, .div_class);

// ===== tb/ucode_src.sv
`timescale 1ns/1ps
// ----------------------------------------
// control store register model
// ----------------------------------------
module ucode_src (
  input  wire logic sys_clk,
  output logic      register_clock_strobe,
  output logic [3:0] exp_add_field,
  output logic [1:0] exp_reg_field,
  output logic      add_sub_128_ctl,
  output logic      normalize_uop,
  output logic      align_uop,
  output logic      main_mult_uop,
  output logic      main_div_uop,
  output logic      load_exp_from_latch,
  output logic      double_prec_sel,
  output logic [15:0] data_latch,
  output logic [4:0] instr_reg,
  output logic      shift_clock,
  output logic      div_classify,
  output logic      div_finalize,
  output logic      quotient_ge_one
);
  logic [8:0] ctl = 9'h000; // packed strobes and step decodes
  assign {div_finalize, div_classify, shift_clock, main_div_uop, main_mult_uop,
          align_uop, normalize_uop, add_sub_128_ctl, register_clock_strobe} = ctl;
  initial begin
    exp_add_field = 4'h0;
    exp_reg_field = 2'h0;
    load_exp_from_latch = 1'b0; // latch always feeds b
    double_prec_sel = 1'b1;
    data_latch = 16'h0000;
    instr_reg = 5'h00;
    quotient_ge_one = 1'b0;
  end
  // one microinstruction for one clock, then idle
  task automatic op(input logic [3:0] a, input logic [1:0] r, input logic [8:0] c,
                    input logic [15:0] d);
    @(posedge sys_clk);
    #1;
    ctl = c;
    exp_add_field = a;
    exp_reg_field = r;
    data_latch = d;
    @(posedge sys_clk);
    #1;
    ctl = 9'h000;
    exp_reg_field = 2'h0;
    data_latch = ~d; // stale latch never looks valid
  endtask
endmodule // ucode_src

// ===== tb/fp_exponent_control_tb.sv
`timescale 1ns/1ps
`include "fp_exp_defines.svh"
`define CHK(nm, ex, sn) begin compares++; if ((sn) !== (ex)) begin mismatches++; \
  $display("[ERR] %s expected %0h seen %0h", nm, ex, sn); end end
module fp_exponent_control_tb;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  wire logic register_clock_strobe, add_sub_128_ctl, normalize_uop, align_uop, main_mult_uop;
  wire logic main_div_uop, load_exp_from_latch, double_prec_sel, shift_clock, div_classify;
  wire logic div_finalize, quotient_ge_one, exp_carry_flag, exp_is_zero, count_near_zero;
  wire logic fp_interrupt;
  wire logic [3:0] exp_add_field;
  wire logic [1:0] exp_reg_field;
  wire logic [15:0] data_latch;
  wire logic [4:0] instr_reg;
  wire logic [7:0] exp_reg, shift_cnt;
  wire logic [2:0] div_class;
  localparam logic [8:0] S = 9'h001, AS = 9'h002, NO = 9'h004, SH = 9'h040;
  localparam logic [8:0] CL = 9'h080, FN = 9'h100;
  logic [4:0] rom_a [8] = '{`ROM_ADDR_ADD_S, `ROM_ADDR_ADD_D, `ROM_ADDR_MUL_S,
    `ROM_ADDR_MUL_D, `ROM_ADDR_DIV_S, `ROM_ADDR_DIV_D, `ROM_ADDR_FLT, `ROM_ADDR_FIX};
  logic [7:0] rom_v [8] = '{`ROM_VAL_ADD_S, `ROM_VAL_ADD_D, `ROM_VAL_MUL_S,
    `ROM_VAL_MUL_D, `ROM_VAL_DIV_S, `ROM_VAL_DIV_D, `ROM_VAL_CONV, `ROM_VAL_CONV};
  always #2.5 sys_clk = ~sys_clk;
  ucode_src pm (.*);
  fp_exponent_control DUT (.*);
  // expected divide class from first flag and stored exponent
  function automatic logic [2:0] dcls(input logic [7:0] e, input logic f);
    if (f) return (e == 8'hFF) ? 3'h6 : (e[7] ? 3'h2 : 3'h3);
    return (e == 8'hFF) ? 3'h1 : 3'h0;
  endfunction
  // whole divide exponent flow: load, subtract, classify, finalize
  task automatic div(input logic [7:0] e1, input logic [7:0] e2, input logic q);
    int d;
    logic [7:0] e;
    logic f;
    logic [2:0] c;
    d = int'(e1) - int'(e2) + 128;
    f = (d < 0) || (d > 255);
    e = d[7:0];
    c = dcls(e, f);
    pm.quotient_ge_one = q;
    pm.op(4'h1, 2'h1, S, {e1, 8'h00});
    pm.op(4'hA, 2'h1, S | AS, {e2, 8'h00});
    `CHK("div flag", f, exp_carry_flag)
    `CHK("div exp", e, exp_reg)
    pm.op(4'hC, 2'h0, S | CL, 16'h0000);
    `CHK("ones flag", e == 8'hFF, exp_carry_flag)
    `CHK("class", c, div_class)
    `CHK("irq", c == 3'h2 || c == 3'h3, fp_interrupt)
    pm.op(4'h0, 2'h0, S | FN, 16'h0000);
    `CHK("final", c[0] ? 8'hFF : (c[1] ? 8'h00 : e + q), exp_reg)
  endtask
  task automatic complete_run;
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // hang guard, well above the roughly 130 cycles needed
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    #1 rstn = 1'b1;
    `CHK("rst flag", 1'b0, exp_carry_flag)
    `CHK("rst exp", 8'h00, exp_reg)
    `CHK("rst zero", 1'b1, exp_is_zero)
    for (int i = 0; i < 8; i++) begin
      pm.instr_reg = rom_a[i];
      pm.op(4'h4, 2'h1, S, 16'h0000);
      `CHK("rom", rom_v[i], exp_reg)
    end
    div(8'hFF, 8'h00, 1'b0);
    div(8'h80, 8'h00, 1'b0);
    div(8'h7F, 8'h00, 1'b1);
    div(8'h80, 8'h80, 1'b1);
    div(8'h80, 8'h80, 1'b0);
    div(8'h00, 8'h81, 1'b0);
    div(8'h00, 8'hFF, 1'b1);
    for (int k = 0; k < 3; k++) begin
      pm.op(4'h1, 2'h3, S, 16'h0300);
      `CHK("cnt load", 8'h03, shift_cnt)
      for (int i = 0; i < 4; i++) begin
        pm.op(4'h0, 2'h0, (9'h008 << k) | SH, 16'h0000);
        `CHK("cnt", (i < 3) ? 8'(2 - i) : 8'h00, shift_cnt)
        `CHK("near", i >= 1, count_near_zero)
      end
    end
    pm.op(4'h1, 2'h3, S, 16'h0200);
    pm.op(4'h0, 2'h0, SH, 16'h0000);
    `CHK("cnt idle", 8'h02, shift_cnt)
    pm.op(4'h1, 2'h2, S, 16'h0500);
    `CHK("cond load", 8'h05, shift_cnt)
    pm.op(4'h1, 2'h1, S, 16'h0100);
    pm.op(4'h0, 2'h0, S | NO, 16'h0000);
    `CHK("norm exp", 8'h00, exp_reg)
    pm.op(4'h0, 2'h0, S | NO, 16'h0000);
    `CHK("norm exp", 8'hFF, exp_reg)
    `CHK("norm flag", 1'b1, exp_carry_flag)
    pm.op(4'h1, 2'h2, S, 16'h0900);
    `CHK("cond hold", 8'h05, shift_cnt)
    pm.double_prec_sel = 1'b0;
    pm.op(4'h1, 2'h1, S, 16'h9E00);
    `CHK("neg single", 8'hC3, exp_reg)
    pm.op(4'h1, 2'h1, S, 16'h1E00);
    `CHK("pos single", 8'h3C, exp_reg)
    pm.op(4'hB, 2'h1, S, 16'h0000);
    `CHK("dec", 8'h3B, exp_reg)
    pm.op(4'hC, 2'h1, S, 16'h0000);
    `CHK("inc", 8'h3C, exp_reg)
    pm.double_prec_sel = 1'b1;
    pm.op(4'h9, 2'h1, S, 16'h1000);
    `CHK("add", 8'h4C, exp_reg)
    complete_run();
  end
endmodule // fp_exponent_control_tb
